// *** inc/thermal_alert_pkg.sv ***
// Constants and carrier types for the thermal limit and alert logic.
// Assumes a register port driven by a serial-bus front end that is outside this block.
package thermal_alert_pkg;

    // ========================================================================
    // Register pointers, as seen by the bus front end
    // ========================================================================
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_UPPER = 8'h02;
    localparam logic [7:0] ADDR_LOWER = 8'h03;
    localparam logic [7:0] ADDR_CRIT = 8'h04;
    localparam logic [7:0] ADDR_TEMP = 8'h05;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [15:0] RST_CONFIG = 16'h0001;
    localparam logic [15:0] RST_LIMIT = 16'h0000;

    // ========================================================================
    // Configuration field positions
    // ========================================================================
    localparam int HYST_LSB = 9;
    localparam int SLEEP_BIT = 8;
    localparam int CRIT_LOCK_BIT = 7;
    localparam int WIN_LOCK_BIT = 6;
    localparam int CLEAR_BIT = 5;
    localparam int PIN_STATE_BIT = 4;
    localparam int ENABLE_BIT = 3;
    localparam int CRIT_ONLY_BIT = 2;
    localparam int POLARITY_BIT = 1;
    localparam int MODE_BIT = 0;

    // ========================================================================
    // Temperature fields: sign at bit 12, quarter degree at bit 2
    // ========================================================================
    localparam int TEMP_MSB = 12;
    localparam int TEMP_LSB = 2;
    localparam int CRIT_FLAG_BIT = 15;
    localparam int UPPER_FLAG_BIT = 14;
    localparam int LOWER_FLAG_BIT = 13;

    // Hysteresis in quarter-degree steps: 0, 1.5, 3 and 6 degrees.
    localparam logic [11:0] HYST_NONE_Q = 12'h000;
    localparam logic [11:0] HYST_1P5_Q = 12'h006;
    localparam logic [11:0] HYST_3_Q = 12'h00C;
    localparam logic [11:0] HYST_6_Q = 12'h018;

    // Resolution codes of the sensor.
    localparam logic [1:0] RES_HALF = 2'h0;
    localparam logic [1:0] RES_QUARTER = 2'h1;
    localparam logic [1:0] RES_EIGHTH = 2'h2;

    // Request from the bus front end; one-cycle strobes.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // One conversion result from the sensor front end.
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } temp_sample_t;

    // Open-drain alert pin: the level it would drive and its output enable.
    typedef struct packed {
        logic out;
        logic oe;
    } alert_pin_t;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] crit;
        logic [1:0] hyst;
        logic sleep_control;
        logic crit_limit_lock;
        logic win_lock;
        logic enable;
        logic crit_only_alert;
        logic alert_polarity;
        logic int_mode;
        logic above_flag;
        logic below_flag;
        logic crit_flag;
        logic int_latch;
        logic [15:0] temp_data;
        logic [15:0] rd_data;
    } alert_state_t;

endpackage : thermal_alert_pkg

// *** verilog/thermal_limit_alert_logic.sv ***
// Limit registers, configuration, windowed compare with hysteresis and alert pin control.
// Assumes the bus front end gives one-cycle read and write strobes with a register pointer,
// and the sensor front end gives one-cycle sample strobes; all synchronous to sys_clk.
//
// Functional notes
// - Hysteresis code 00 none, 01 1.5, 10 3, 11 6 degrees, on every limit.
// - Above-window alarm sets rising past upper; clears at upper minus hysteresis.
// - Below-window alarm sets below lower minus hysteresis; clears reaching lower.
// - Sleep bit stops conversion, alert events and temperature data updates.
// - Sleep bit cannot be set while any lock is set; clearing always allowed.
// - Register reads and writes keep working while asleep.
// - Critical lock makes critical limit read-only; only reset clears the lock.
// - Window lock makes upper and lower limits read-only until reset.
// - Clear bit releases latched alert; write-only, reads 0, ignored in comparator mode.
// - Read-only status bit shows whether the alert pin is asserted.
// - Enable bit gates the alert; frozen while any lock is set.
// - Critical-only bit limits alert to critical; frozen under window lock.
// - Polarity bit picks the asserted pin level, default low.
// - Mode bit: 0 comparator, 1 interrupt, default interrupt.
// - Limits are two's complement in bits 12 to 2, temperature in bits 12 to 0, sign bit 12.
// - Comparisons use only temperature bits 12 to 2.
// - Data reads show eleven, twelve or thirteen bits at the finer resolutions.
// - Alert on rising above upper and on falling to upper minus hysteresis.
// - Alert on dropping below lower minus hysteresis and on rising back to lower.
// - In comparator mode, critical alert holds until temperature at or below critical minus hysteresis.
// - Hysteresis field sits at configuration bits 10 and 9.
// - Hysteresis field writes ignored while any lock is set.
`timescale 1ns/1ps

module thermal_limit_alert_logic
    import thermal_alert_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    input wire temp_sample_t temp_sample,
    input wire logic [1:0] resolution_select,
    output logic convert_enable,
    input wire logic alert_in,
    output alert_pin_t alert_pin
);

    alert_state_t s_q;
    alert_state_t s_d;

    logic any_lock;
    logic [1:0] hyst_sel;
    logic [11:0] hyst_q;
    logic signed [11:0] t_now;
    logic signed [11:0] up_t;
    logic signed [11:0] lo_t;
    logic signed [11:0] cr_t;
    logic condition;
    logic new_event;
    logic asserted;
    logic [15:0] cfg_view;
    logic [15:0] temp_masked;

    // ========================================================================
    // Helpers
    // ========================================================================

    // Quarter-degree value of bits 12..2, sign extended by one bit for headroom.
    function automatic logic signed [11:0] quarter(input logic [15:0] v);
        quarter = signed'({v[TEMP_MSB], v[TEMP_MSB:TEMP_LSB]});
    endfunction : quarter

    // Limit values are stored with unused bits forced to zero.
    function automatic logic [15:0] limit_bits(input logic [15:0] v);
        limit_bits = {3'h0, v[TEMP_MSB:TEMP_LSB], 2'h0};
    endfunction : limit_bits

    // ========================================================================
    // Decode of the hysteresis field and sample alignment
    // ========================================================================
    assign any_lock = s_q.crit_limit_lock | s_q.win_lock;
    assign hyst_sel = s_q.hyst;

    // Hysteresis magnitude in quarter degrees, applied to all three limits.
    always_comb begin
        case (hyst_sel)
            2'h0: hyst_q = HYST_NONE_Q;
            2'h1: hyst_q = HYST_1P5_Q;
            2'h2: hyst_q = HYST_3_Q;
            default: hyst_q = HYST_6_Q;
        endcase
    end

    assign t_now = quarter(temp_sample.value);
    assign up_t = quarter(s_q.upper);
    assign lo_t = quarter(s_q.lower);
    assign cr_t = quarter(s_q.crit);

    // Data reads hide bits finer than the selected resolution.
    always_comb begin
        case (resolution_select)
            RES_HALF: temp_masked = {s_q.temp_data[15:3], 3'h0};
            RES_QUARTER: temp_masked = {s_q.temp_data[15:2], 2'h0};
            RES_EIGHTH: temp_masked = {s_q.temp_data[15:1], 1'h0};
            default: temp_masked = s_q.temp_data;
        endcase
    end

    // ========================================================================
    // Alert decision
    // ========================================================================

    // Window flags only count when critical-only is off.
    assign condition = s_q.crit_flag |
        (~s_q.crit_only_alert & (s_q.above_flag | s_q.below_flag));

    // Comparator mode follows the condition; interrupt mode shows the latch.
    assign asserted = s_q.enable &
        (s_q.int_mode ? s_q.int_latch : condition);

    // Open drain: drive low when the pin must sit at its low level.
    // An active-high alert is released to the pull-up and held low when idle.
    assign alert_pin.out = 1'b0;
    assign alert_pin.oe = asserted ^ s_q.alert_polarity;

    assign convert_enable = ~s_q.sleep_control;
    assign reg_rdata = s_q.rd_data;

    // Status bit 4 copies the internal asserted signal, not alert_in; clear bit always reads zero.
    always_comb begin
        cfg_view = 16'h0000;
        cfg_view[HYST_LSB +: 2] = s_q.hyst;
        cfg_view[SLEEP_BIT] = s_q.sleep_control;
        cfg_view[CRIT_LOCK_BIT] = s_q.crit_limit_lock;
        cfg_view[WIN_LOCK_BIT] = s_q.win_lock;
        cfg_view[PIN_STATE_BIT] = asserted;
        cfg_view[ENABLE_BIT] = s_q.enable;
        cfg_view[CRIT_ONLY_BIT] = s_q.crit_only_alert;
        cfg_view[POLARITY_BIT] = s_q.alert_polarity;
        cfg_view[MODE_BIT] = s_q.int_mode;
    end

    // ========================================================================
    // Next-state logic
    // ========================================================================

    // Flags move only on a sample while awake; register access never stalls.
    always_comb begin
        s_d = s_q;
        new_event = 1'b0;
        if (temp_sample.valid && !s_q.sleep_control) begin
            s_d.temp_data = {s_q.crit_flag, s_q.above_flag, s_q.below_flag,
                temp_sample.value[TEMP_MSB:0]};
            if (!s_q.above_flag && t_now > up_t) begin
                s_d.above_flag = 1'b1;
            end else if (s_q.above_flag && t_now <= up_t - signed'(hyst_q)) begin
                s_d.above_flag = 1'b0;
            end
            if (!s_q.below_flag && t_now < lo_t - signed'(hyst_q)) begin
                s_d.below_flag = 1'b1;
            end else if (s_q.below_flag && t_now >= lo_t) begin
                s_d.below_flag = 1'b0;
            end
            if (!s_q.crit_flag && t_now > cr_t) begin
                s_d.crit_flag = 1'b1;
            end else if (s_q.crit_flag && t_now <= cr_t - signed'(hyst_q)) begin
                s_d.crit_flag = 1'b0;
            end
            // Status bits in the data word track the freshly computed flags.
            s_d.temp_data[CRIT_FLAG_BIT] = s_d.crit_flag;
            s_d.temp_data[UPPER_FLAG_BIT] = s_d.above_flag;
            s_d.temp_data[LOWER_FLAG_BIT] = s_d.below_flag;
            // Crossing out of or back into a window is an event either way.
            new_event = (s_d.crit_flag != s_q.crit_flag) ||
                (!s_q.crit_only_alert && ((s_d.above_flag != s_q.above_flag) ||
                (s_d.below_flag != s_q.below_flag)));
        end

        // Register writes; the bus keeps working even while asleep.
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_CONFIG: begin
                    if (!any_lock) begin
                        s_d.hyst = reg_req.wdata[HYST_LSB +: 2];
                        s_d.enable = reg_req.wdata[ENABLE_BIT];
                    end
                    if (!reg_req.wdata[SLEEP_BIT] || !any_lock) begin
                        s_d.sleep_control = reg_req.wdata[SLEEP_BIT];
                    end
                    if (!s_q.win_lock) begin
                        s_d.crit_only_alert = reg_req.wdata[CRIT_ONLY_BIT];
                    end
                    // Locks are set-only; only a reset takes them down.
                    s_d.crit_limit_lock = s_q.crit_limit_lock |
                        reg_req.wdata[CRIT_LOCK_BIT];
                    s_d.win_lock = s_q.win_lock | reg_req.wdata[WIN_LOCK_BIT];
                    s_d.alert_polarity = reg_req.wdata[POLARITY_BIT];
                    s_d.int_mode = reg_req.wdata[MODE_BIT];
                    if (reg_req.wdata[CLEAR_BIT] && s_q.int_mode) begin
                        s_d.int_latch = 1'b0;
                    end
                end
                ADDR_UPPER: begin
                    if (!s_q.win_lock) begin
                        s_d.upper = limit_bits(reg_req.wdata);
                    end
                end
                ADDR_LOWER: begin
                    if (!s_q.win_lock) begin
                        s_d.lower = limit_bits(reg_req.wdata);
                    end
                end
                ADDR_CRIT: begin
                    if (!s_q.crit_limit_lock) begin
                        s_d.crit = limit_bits(reg_req.wdata);
                    end
                end
                default: begin
                end
            endcase
        end

        // A new event in the same cycle as a clear wins, so it is never lost.
        if (new_event && s_q.int_mode) begin
            s_d.int_latch = 1'b1;
        end

        // Read data is captured one cycle after the strobe; unmapped reads give zero.
        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_CONFIG: s_d.rd_data = cfg_view;
                ADDR_UPPER: s_d.rd_data = s_q.upper;
                ADDR_LOWER: s_d.rd_data = s_q.lower;
                ADDR_CRIT: s_d.rd_data = s_q.crit;
                ADDR_TEMP: s_d.rd_data = temp_masked;
                default: s_d.rd_data = 16'h0000;
            endcase
        end
    end

    // ========================================================================
    // State register
    // ========================================================================

    // Synchronous reset stands in for the internal power-on reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.upper <= RST_LIMIT;
            s_q.lower <= RST_LIMIT;
            s_q.crit <= RST_LIMIT;
            s_q.int_mode <= RST_CONFIG[MODE_BIT];
        end else begin
            s_q <= s_d;
        end
    end

endmodule : thermal_limit_alert_logic

// *** tb/thermal_alert_monitor.sv ***
// Port-level checks for the thermal limit and alert block.
// Assumes it is bound to the block and sees only the block's ports.
`timescale 1ns/1ps

module thermal_alert_monitor
    import thermal_alert_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire temp_sample_t temp_sample,
    input wire logic [1:0] resolution_select,
    input wire logic convert_enable,
    input wire logic alert_in,
    input wire alert_pin_t alert_pin
);
    // ==========
    // Checks
    // All checks run on the one clock and stay quiet while reset is low.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Configuration accesses, shared by several checks.
    sequence s_cfg_wr;
        reg_req.wr && reg_req.addr == ADDR_CONFIG;
    endsequence
    sequence s_cfg_rd;
        reg_req.rd && reg_req.addr == ADDR_CONFIG;
    endsequence

    chk_pin_open_drain: assert property (!alert_pin.out)
        else $error("alert pin driven high");
    chk_wake_always: assert property (s_cfg_wr ##0 !reg_req.wdata[SLEEP_BIT] |=> convert_enable)
        else $error("sleep bit not cleared");
    // A write in the same cycle may move the pin legally, so it is excluded.
    chk_sleep_frozen: assert property (!convert_enable && temp_sample.valid
        && !reg_req.wr |=> $stable(alert_pin.oe))
        else $error("alert moved while asleep");
    chk_clear_reads_zero: assert property (s_cfg_rd
        |=> reg_rdata[CLEAR_BIT] == 1'b0 && reg_rdata[15:11] == 5'h00)
        else $error("clear or spare bits read nonzero");
    chk_status_pin: assert property (s_cfg_rd
        |=> reg_rdata[PIN_STATE_BIT] == ($past(alert_pin.oe) ^ reg_rdata[POLARITY_BIT]))
        else $error("status bit disagrees with pin");
    chk_limit_format: assert property (reg_req.rd
        && reg_req.addr inside {[ADDR_UPPER:ADDR_CRIT]}
        |=> reg_rdata[15:13] == 3'h0 && reg_rdata[1:0] == 2'h0)
        else $error("limit spare bits nonzero");
    chk_half_res_mask: assert property (reg_req.rd && reg_req.addr == ADDR_TEMP
        && resolution_select == RES_HALF |=> reg_rdata[2:0] == 3'h0)
        else $error("fine bits shown at half resolution");
    chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule : thermal_alert_monitor

bind thermal_limit_alert_logic thermal_alert_monitor u_monitor (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .temp_sample(temp_sample),
    .resolution_select(resolution_select),
    .convert_enable(convert_enable),
    .alert_in(alert_in),
    .alert_pin(alert_pin)
);

// *** tb/thermal_host_model.sv ***
// Host controller model: register writes and reads on the block's register port.
// Assumes the caller is a testbench process on the same clock.
`timescale 1ns/1ps

module thermal_host_model
    import thermal_alert_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [1:0] resolution_select,
    input wire logic [15:0] reg_rdata,
    output reg_req_t reg_req
);
    // ==========
    // Bus cycles
    // Idle request at time zero.
    initial reg_req = '0;

    // One write; address and data are scrambled once released.
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a inside {ADDR_UPPER, ADDR_LOWER, ADDR_CRIT}) begin
            v = v & 16'h1FFC;
            if (resolution_select == RES_HALF) v[2] = 1'b0;
        end
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask : write_reg

    // One read; data is taken once the answer has settled.
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~reg_req.wdata};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: reg_req.wdata};
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : read_reg
endmodule : thermal_host_model

// *** tb/thermal_limit_alert_logic_tb.sv ***
// Self-checking bench for the thermal limit and alert block.
// Assumes the host model drives the register port and this bench drives samples.
`timescale 1ns/1ps

module thermal_limit_alert_logic_tb;
    import thermal_alert_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t reg_req;
    logic [15:0] reg_rdata;
    temp_sample_t temp_sample = '0;
    logic [1:0] resolution_select = RES_QUARTER;
    logic convert_enable;
    alert_pin_t alert_pin;
    int bad_count = 0;
    int checks = 0;
    logic [15:0] lim [3] = '{16'h0190, 16'h1FF0, 16'h0320};
    // Steps of {configuration, sample, expected pin enable}.
    logic [32:0] tbl [33] = '{
        {16'h0008, 16'h0193, 1'b0}, {16'h0008, 16'h0194, 1'b1}, {16'h0008, 16'h0190, 1'b0},
        {16'h0208, 16'h0194, 1'b1}, {16'h0208, 16'h017C, 1'b1}, {16'h0208, 16'h0178, 1'b0},
        {16'h0408, 16'h0194, 1'b1}, {16'h0408, 16'h0164, 1'b1}, {16'h0408, 16'h0160, 1'b0},
        {16'h0608, 16'h0194, 1'b1}, {16'h0608, 16'h0134, 1'b1}, {16'h0608, 16'h0130, 1'b0},
        {16'h040C, 16'h0194, 1'b0}, {16'h040C, 16'h0324, 1'b1}, {16'h040C, 16'h02F4, 1'b1},
        {16'h040C, 16'h02F0, 1'b0}, {16'h0408, 16'h1FD0, 1'b0}, {16'h0408, 16'h1FBC, 1'b1},
        {16'h0408, 16'h1FEC, 1'b1}, {16'h0408, 16'h1FF0, 1'b0}, {16'h0029, 16'h1FF0, 1'b0},
        {16'h0009, 16'h0194, 1'b1}, {16'h0009, 16'h0194, 1'b1}, {16'h0029, 16'h0194, 1'b0},
        {16'h0009, 16'h0190, 1'b1}, {16'h0029, 16'h1FBC, 1'b1}, {16'h0029, 16'h1FF0, 1'b1},
        {16'h0028, 16'h0194, 1'b1}, {16'h000A, 16'h0194, 1'b0}, {16'h000A, 16'h0190, 1'b1},
        {16'h0000, 16'h0194, 1'b0}, {16'h0008, 16'h0190, 1'b0}, {16'h0108, 16'h0194, 1'b0}};

    // ==========
    // Clock, design and host
    always #2 sys_clk = ~sys_clk;

    // The alert wire has a pull-up, so its level is low only while driven.
    thermal_limit_alert_logic DUT (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .temp_sample(temp_sample),
        .resolution_select(resolution_select),
        .convert_enable(convert_enable),
        .alert_in(~alert_pin.oe),
        .alert_pin(alert_pin)
    );

    thermal_host_model host (
        .sys_clk(sys_clk),
        .resolution_select(resolution_select),
        .reg_rdata(reg_rdata),
        .reg_req(reg_req)
    );

    // ==========
    // Shared tasks
    task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic reg_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.read_reg(a, d);
        check($sformatf("reg %h", a), e, d);
    endtask : reg_chk

    // One sample strobe; the pin is looked at after flags have landed.
    task automatic sample(input logic [15:0] v);
        @(posedge sys_clk);
        temp_sample <= '{valid: 1'b1, value: v};
        @(posedge sys_clk);
        temp_sample.valid <= 1'b0;
        @(negedge sys_clk);
    endtask : sample

    task report_and_stop;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // A hung run is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop;
    end

    // ==========
    // Main sequence: reset, limits, compare table, sleep, resolution, locks.
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_chk(ADDR_CONFIG, RST_CONFIG);
        check("convert", 16'h0001, {15'h0, convert_enable});
        for (int i = 0; i < 3; i++) begin
            reg_chk(ADDR_UPPER + i[7:0], RST_LIMIT);
            host.write_reg(ADDR_UPPER + i[7:0], lim[i]);
            reg_chk(ADDR_UPPER + i[7:0], lim[i]);
        end
        foreach (tbl[i]) begin
            host.write_reg(ADDR_CONFIG, tbl[i][32:17]);
            sample(tbl[i][16:1]);
            check("alert oe", {15'h0, tbl[i][0]}, {15'h0, alert_pin.oe});
        end
        check("convert", 16'h0000, {15'h0, convert_enable});
        reg_chk(ADDR_TEMP, 16'h0190);
        lim[2] = 16'h0300;
        host.write_reg(ADDR_CRIT, lim[2]);
        reg_chk(ADDR_CRIT, lim[2]);
        host.write_reg(ADDR_CONFIG, 16'h0008);
        sample(16'h0197);
        // The above-window alarm is now driving the pin, so the status bit must read one.
        check("alert oe", 16'h0001, {15'h0, alert_pin.oe});
        reg_chk(ADDR_CONFIG, 16'h0018);
        for (int r = 0; r < 4; r++) begin
            @(posedge sys_clk);
            resolution_select <= r[1:0];
            reg_chk(ADDR_TEMP, 16'h4000 | (16'h0197 & ~((16'h8 >> r) - 16'h1)));
        end
        sample(16'h0100);
        host.write_reg(ADDR_CONFIG, 16'h00C8);
        reg_chk(ADDR_CONFIG, 16'h00C8);
        host.write_reg(ADDR_CONFIG, 16'h0706);
        reg_chk(ADDR_CONFIG, 16'h00CA);
        check("convert", 16'h0001, {15'h0, convert_enable});
        for (int i = 0; i < 3; i++) begin
            host.write_reg(ADDR_UPPER + i[7:0], 16'h0004);
            reg_chk(ADDR_UPPER + i[7:0], lim[i]);
        end
        reg_chk(8'h09, 16'h0000);
        report_and_stop;
    end
endmodule : thermal_limit_alert_logic_tb
